// ---- common/vdc_map.svh ----
`ifndef VDC_MAP_SVH
`define VDC_MAP_SVH
// Register byte offsets
`define VDC_OFF_CTRL 8'h00
`define VDC_OFF_IRQ_STAT 8'h04
`define VDC_OFF_IRQ_CLR 8'h08
`define VDC_OFF_IRQ_EN 8'h0C
// Control register fields
`define VDC_BIT_ON 15
`define VDC_BIT_IDLE_STOP 13
`define VDC_BIT_DIR 11
`define VDC_BIT_BG_STABLE 10
`define VDC_BIT_REF_STABLE 9
`define VDC_BIT_EVENT 8
`define VDC_LVL_HI 3
`define VDC_LVL_LO 0
// Writable mask of the control register
`define VDC_CTRL_WMASK 32'h0000A80F
// Interrupt status bits
`define VDC_IRQ_EVT_RISE 0
`define VDC_IRQ_EVT_FALL 1
`define VDC_IRQ_REF_LOST 2
`define VDC_IRQ_WIDTH 3
`define VDC_IRQ_RESET 3'h0
`endif

// ---- common/vdc_pkg.sv ----
package vdc_pkg;
  typedef enum logic [1:0] {
    VDC_OFF = 2'b00,
    VDC_WAIT_REF = 2'b01,
    VDC_RUN = 2'b10,
    VDC_HALT = 2'b11
  } vdc_state_type;
endpackage

// ---- common/vdc_sync_if.sv ----
interface vdc_sync_if;
  logic cmp_above;
  logic cmp_below;
  logic bg_stable;
  logic ref_stable;
  modport src (output cmp_above, output cmp_below, output bg_stable, output ref_stable);
  modport dst (input cmp_above, input cmp_below, input bg_stable, input ref_stable);
endinterface

// ---- rtl/vdc_sync.sv ----
module vdc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } vdc_sync_st_type;
  vdc_sync_st_type st_q, st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = i_async;
    st_d.stab = st_q.meta;
  end

  // Two-flop pipeline
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.stab;
endmodule

// ---- rtl/vdc_analog_in.sv ----
module vdc_analog_in (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_cmp_above,
  input wire logic i_cmp_below,
  input wire logic i_bg_stable,
  input wire logic i_ref_stable,
  vdc_sync_if.src sync_out
);
  logic [3:0] synced;

  // Analog status arrives asynchronously
  vdc_sync #(.WIDTH(4)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async({i_ref_stable, i_bg_stable, i_cmp_below, i_cmp_above}),
    .o_sync(synced)
  );

  // Hand synchronised levels to the controller
  assign sync_out.cmp_above = synced[0];
  assign sync_out.cmp_below = synced[1];
  assign sync_out.bg_stable = synced[2];
  assign sync_out.ref_stable = synced[3];
endmodule

// ---- rtl/vdc_top.sv ----
`include "vdc_map.svh"
// Notes on behaviour
// RQ1: Bit 15 set turns the detector on; clear turns it off.
// RQ2: Bit 13 set halts detection while the chip idles; clear keeps it running.
// RQ3: Bit 11 picks at-or-above versus at-or-below; bits 3:0 hold trip level.
// RQ4: Read-only bit 10 shows band-gap stable, maintained by hardware.
// RQ5: Bit 9 shows reference stable; event interrupt flags raised only while it is one, ref-lost flag while it is zero.
// RQ6: Read-only bit 8 is high while a detection event is active.
// RQ7: Bits 31:16, 14, 12 and 7:4 read zero and ignore writes.
// RQ8: Detector off holds event bit and interrupt flag cleared.
module vdc_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_idle,
  input wire logic i_cmp_above,
  input wire logic i_cmp_below,
  input wire logic i_bg_stable,
  input wire logic i_ref_stable,
  output logic o_det_enable,
  output logic [3:0] o_trip_level,
  output logic o_detect_event,
  output logic o_irq
);
  typedef struct packed {
    vdc_pkg::vdc_state_type state;
    logic power_on;
    logic idle_stop;
    logic trip_direction;
    logic [3:0] trip_level;
    logic detect_event_active;
    logic [`VDC_IRQ_WIDTH-1:0] irq_stat;
    logic [`VDC_IRQ_WIDTH-1:0] irq_en;
    logic [31:0] rdata;
    logic det_enable;
    logic irq;
    logic idle_s1;
    logic idle_s2;
  } vdc_st_type;

  vdc_st_type st_q, st_d;
  vdc_sync_if sync_bus ();

  // Bring the comparator and reference flags into the clock domain
  vdc_analog_in u_analog (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_cmp_above(i_cmp_above),
    .i_cmp_below(i_cmp_below),
    .i_bg_stable(i_bg_stable),
    .i_ref_stable(i_ref_stable),
    .sync_out(sync_bus.src)
  );

  // Control register image as software sees it
  function automatic logic [31:0] ctrl_image(input vdc_st_type s, input logic bg, input logic rs);
    logic [31:0] v;
    v = 32'h0;
    v[`VDC_BIT_ON] = s.power_on;
    v[`VDC_BIT_IDLE_STOP] = s.idle_stop;
    v[`VDC_BIT_DIR] = s.trip_direction;
    v[`VDC_BIT_BG_STABLE] = bg;
    v[`VDC_BIT_REF_STABLE] = rs;
    v[`VDC_BIT_EVENT] = s.detect_event_active;
    v[`VDC_LVL_HI:`VDC_LVL_LO] = s.trip_level;
    return v & (`VDC_CTRL_WMASK | 32'h00000700); // see RQ7
  endfunction

  // Register address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic cond_met;
  logic running;
  logic new_event;
  logic [`VDC_IRQ_WIDTH-1:0] irq_set;
  logic [`VDC_IRQ_WIDTH-1:0] irq_clr;

  // Main next-state logic
  always_comb begin
    st_d = st_q;
    st_d.idle_s1 = i_idle;
    st_d.idle_s2 = st_q.idle_s1;
    irq_clr = '0;

    // Register writes; unimplemented bits dropped
    if (i_wr && hit(i_addr, `VDC_OFF_CTRL)) begin
      st_d.power_on = i_wdata[`VDC_BIT_ON]; // see RQ1
      st_d.idle_stop = i_wdata[`VDC_BIT_IDLE_STOP]; // see RQ2
      st_d.trip_direction = i_wdata[`VDC_BIT_DIR]; // see RQ3
      st_d.trip_level = i_wdata[`VDC_LVL_HI:`VDC_LVL_LO]; // see RQ3
    end
    if (i_wr && hit(i_addr, `VDC_OFF_IRQ_EN)) begin
      st_d.irq_en = i_wdata[`VDC_IRQ_WIDTH-1:0];
    end
    if (i_wr && hit(i_addr, `VDC_OFF_IRQ_CLR)) begin
      irq_clr = i_wdata[`VDC_IRQ_WIDTH-1:0];
    end

    // Detector sequencing
    unique case (st_q.state)
      vdc_pkg::VDC_OFF: begin
        if (st_q.power_on) begin
          st_d.state = vdc_pkg::VDC_WAIT_REF; // see RQ1
        end
      end
      vdc_pkg::VDC_WAIT_REF: begin
        if (!st_q.power_on) begin
          st_d.state = vdc_pkg::VDC_OFF;
        end else if (st_q.idle_stop && st_q.idle_s2) begin
          st_d.state = vdc_pkg::VDC_HALT; // see RQ2
        end else if (sync_bus.ref_stable) begin
          st_d.state = vdc_pkg::VDC_RUN; // see RQ5
        end
      end
      vdc_pkg::VDC_RUN: begin
        if (!st_q.power_on) begin
          st_d.state = vdc_pkg::VDC_OFF;
        end else if (st_q.idle_stop && st_q.idle_s2) begin
          st_d.state = vdc_pkg::VDC_HALT; // see RQ2
        end else if (!sync_bus.ref_stable) begin
          st_d.state = vdc_pkg::VDC_WAIT_REF; // see RQ5
        end
      end
      vdc_pkg::VDC_HALT: begin
        if (!st_q.power_on) begin
          st_d.state = vdc_pkg::VDC_OFF;
        end else if (!(st_q.idle_stop && st_q.idle_s2)) begin
          st_d.state = vdc_pkg::VDC_WAIT_REF;
        end
      end
    endcase

    running = (st_q.state == vdc_pkg::VDC_RUN);
    // Direction picks which comparator output counts
    cond_met = st_q.trip_direction ? sync_bus.cmp_above : sync_bus.cmp_below; // see RQ3
    // Event tracks the condition only while running; off clears it
    if (!st_q.power_on) begin
      st_d.detect_event_active = 1'b0; // see RQ8
    end else if (running) begin
      st_d.detect_event_active = cond_met; // see RQ6
    end else if (st_q.state == vdc_pkg::VDC_WAIT_REF) begin
      st_d.detect_event_active = 1'b0; // see RQ5
    end
    new_event = running && cond_met && !st_q.detect_event_active;

    // Sticky interrupt status; set wins over clear
    irq_set = '0;
    irq_set[`VDC_IRQ_EVT_RISE] = new_event && st_q.trip_direction && sync_bus.ref_stable; // see RQ5
    irq_set[`VDC_IRQ_EVT_FALL] = new_event && !st_q.trip_direction && sync_bus.ref_stable; // see RQ5
    irq_set[`VDC_IRQ_REF_LOST] = running && !sync_bus.ref_stable;
    if (!st_q.power_on) begin
      st_d.irq_stat = '0; // see RQ8
    end else begin
      st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
    end
    st_d.irq = |(st_q.irq_stat & st_q.irq_en) && st_q.power_on; // see RQ8
    st_d.det_enable = st_q.power_on && (st_q.state != vdc_pkg::VDC_HALT); // see RQ1 RQ2

    // Read data one cycle after the strobe; unmapped reads zero
    st_d.rdata = 32'h0;
    if (i_rd) begin
      if (hit(i_addr, `VDC_OFF_CTRL)) begin
        st_d.rdata = ctrl_image(st_q, sync_bus.bg_stable, sync_bus.ref_stable); // see RQ4 RQ5 RQ6 RQ7
      end else if (hit(i_addr, `VDC_OFF_IRQ_STAT)) begin
        st_d.rdata = {29'h0, st_q.irq_stat};
      end else if (hit(i_addr, `VDC_OFF_IRQ_EN)) begin
        st_d.rdata = {29'h0, st_q.irq_en};
      end
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{state: vdc_pkg::VDC_OFF, irq_stat: `VDC_IRQ_RESET, irq_en: `VDC_IRQ_RESET, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign o_rdata = st_q.rdata;
  assign o_det_enable = st_q.det_enable;
  assign o_trip_level = st_q.trip_level;
  assign o_detect_event = st_q.detect_event_active;
  assign o_irq = st_q.irq;
endmodule

// ---- testbench/vdc_analog_model.sv ----
module vdc_analog_model #(
  parameter int SETTLE = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_en,
  input wire logic [3:0] i_trip,
  input wire logic [3:0] i_supply,
  output logic o_above,
  output logic o_below,
  output logic o_bg_ok,
  output logic o_ref_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Reference settles after power-up and drops at the next clock edge after power is removed
  always @(posedge i_clk_sys) begin
    cnt <= i_en ? (cnt < SETTLE ? cnt + 1 : cnt) : 0;
  end
  assign o_bg_ok = cnt >= SETTLE / 2;
  assign o_ref_ok = cnt >= SETTLE;
  // Comparators only answer while powered, low otherwise
  assign o_above = i_en && i_supply >= i_trip;
  assign o_below = i_en && i_supply <= i_trip;
endmodule

// ---- testbench/vdc_top_sva.sv ----
`include "vdc_map.svh"
module vdc_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ref_stable,
  input wire logic [31:0] o_rdata,
  input wire logic o_det_enable,
  input wire logic [3:0] o_trip_level,
  input wire logic o_detect_event,
  input wire logic o_irq
);
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // Control register accesses
  wire ctl_wr = i_wr && i_addr == `VDC_OFF_CTRL;
  wire ctl_rd = i_rd && i_addr == `VDC_OFF_CTRL;
  // Last power bit written by software; the enable output also drops while halted in idle
  logic on_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_q <= 1'b0;
    end else if (ctl_wr) begin
      on_q <= i_wdata[`VDC_BIT_ON];
    end
  end
  // Register and output relations
  power_follow_a:
    assert property (ctl_wr |-> ##2 o_det_enable == $past(i_wdata[15], 2)) else $error("Enable not following");
  trip_source_a:
    assert property ($changed(o_trip_level) |-> $past(ctl_wr) || $past(ctl_wr, 2)) else $error("Trip changed alone");
  reserved_zero_a:
    assert property (ctl_rd |=> (o_rdata & 32'hFFFF50F0) == 32'h0) else $error("Reserved bits not zero");
  rdata_idle_a:
    assert property (!i_rd |=> o_rdata == 32'h0) else $error("Read data without read");
  off_quiet_a:
    assert property (!on_q [*3] |-> !o_detect_event && !o_irq) else $error("Event while off");
  ref_gate_a:
    assert property (!i_ref_stable [*6] |-> !$rose(o_detect_event)) else $error("Event without reference");
  event_mirror_a:
    assert property (ctl_rd |=> o_rdata[8] == $past(o_detect_event)) else $error("Event bit mismatch");
  irq_mask_a:
    assert property (i_wr && i_addr == `VDC_OFF_IRQ_EN && i_wdata[2:0] == 3'h0 |-> ##2 !o_irq)
      else $error("Masked interrupt high");
  // Main scenarios
  cover property ($rose(o_detect_event));
  cover property ($rose(o_irq));
  cover property (ctl_rd ##1 o_rdata[15]);
endmodule
bind vdc_top vdc_chk u_vdc_chk (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .i_ref_stable,
  .o_rdata, .o_det_enable, .o_trip_level, .o_detect_event, .o_irq);

// ---- testbench/vdc_top_tb_top.sv ----
module vdc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_idle = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] supply = 4'h0;
  logic [31:0] o_rdata;
  logic [3:0] o_trip_level;
  logic above, below, bg_ok, ref_ok, o_det_enable, o_detect_event, o_irq;
  int error_cnt = 0;
  int total_checks = 0;
  vdc_top u_vdc_top (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_idle,
    .i_cmp_above(above), .i_cmp_below(below), .i_bg_stable(bg_ok), .i_ref_stable(ref_ok),
    .o_det_enable, .o_trip_level, .o_detect_event, .o_irq);
  vdc_analog_model u_vdc_analog_model (.i_clk_sys, .i_en(o_det_enable), .i_trip(o_trip_level),
    .i_supply(supply), .o_above(above), .o_below(below), .o_bg_ok(bg_ok), .o_ref_ok(ref_ok));
  // Clock, 20 ns period
  initial forever #10 i_clk_sys = ~i_clk_sys;
  // Comparison, bus and wait helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(n, o_rdata, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  // Test sequence
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    rd("ctrl", 8'h00, 32'h0);
    rd("hole", 8'h10, 32'h0);
    wr(8'h00, 32'hFFFF7FFF);
    rd("ctrl", 8'h00, 32'h280F);
    chk("trip", 32'(o_trip_level), 32'hF);
    $display("fields done");
    supply <= 4'h3;
    wr(8'h00, 32'h800A);
    tick(20);
    chk("power", 32'(o_det_enable), 32'h1);
    rd("ctrl", 8'h00, 32'h870A);
    wr(8'h0C, 32'h7);
    tick(3);
    chk("irq", 32'(o_irq), 32'h1);
    rd("stat", 8'h04, 32'h2);
    wr(8'h08, 32'h7);
    tick(3);
    chk("irq", 32'(o_irq), 32'h0);
    supply <= 4'h9;
    wr(8'h00, 32'h880A);
    tick(6);
    rd("ctrl", 8'h00, 32'h8E0A);
    supply <= 4'hA;
    tick(6);
    rd("ctrl", 8'h00, 32'h8F0A);
    rd("stat", 8'h04, 32'h1);
    wr(8'h0C, 32'h0);
    tick(3);
    chk("irq", 32'(o_irq), 32'h0);
    $display("events done");
    wr(8'h00, 32'hA80A);
    i_idle <= 1'b1;
    tick(4);
    supply <= 4'h2;
    tick(6);
    rd("ctrl", 8'h00, 32'hA90A);
    @(posedge i_clk_sys);
    i_idle <= 1'b0;
    tick(16);
    rd("ctrl", 8'h00, 32'hAE0A);
    wr(8'h00, 32'h880A);
    i_idle <= 1'b1;
    supply <= 4'hA;
    tick(6);
    rd("ctrl", 8'h00, 32'h8F0A);
    chk("event", 32'(o_detect_event), 32'h1);
    wr(8'h0C, 32'h7);
    wr(8'h00, 32'h080A);
    i_idle <= 1'b0;
    tick(6);
    rd("ctrl", 8'h00, 32'h080A);
    rd("stat", 8'h04, 32'h0);
    chk("irq", 32'(o_irq), 32'h0);
    chk("power", 32'(o_det_enable), 32'h0);
    $display("idle and off done");
    complete_run();
  end
endmodule
